/* File: rtl/ssms_defs.svh */
// timing counts and default tunables for the speed setpoint / mode select block
// assumes a 125 MHz clock and speed values in rpm, rates in rpm per second
`ifndef SSMS_DEFS_SVH
`define SSMS_DEFS_SVH

`define SSMS_CLK_HZ 125000000
`define SSMS_FAST_DELAY_MS 3000
`define SSMS_FAST_MULT 3
`define SSMS_SLOW_RATE_RPS 16'h000A
`define SSMS_SYNC_RATE_RPS 16'h0002
`define SSMS_FREQ_RATE_RPS 16'h0001
`define SSMS_SYNC_WIN_RPM 16'h000A
`define SSMS_MIN_LOAD_PCT 3
`define SSMS_STEP_HZ 1000
`define SSMS_STEP_CYC (`SSMS_CLK_HZ / `SSMS_STEP_HZ)

`endif

/* File: rtl/ssms_pkg.sv */
// types shared by the speed setpoint / mode select block
// no constants here; numbers live in ssms_defs.svh
package ssms_pkg;
    typedef enum logic [1:0] {SSMS_SPEED, SSMS_FREQ, SSMS_UNIT_LOAD} ssms_mode_e;

    // breaker and contact states, 1 = closed
    typedef struct packed {
        logic gen_brk;
        logic tie_brk;
        logic arm_contact;
        logic dyn_contact;
    } ssms_contacts_s;

    // configuration selections
    typedef struct packed {
        logic gen_app;
        logic arm_feature;
        logic loadshare_cfg;
        logic discrete_cfg;
        logic arm_contact_cfg;
        logic dyn_contact_cfg;
        logic min_load_en;
        logic valve_load;
    } ssms_cfg_s;
endpackage

/* File: rtl/ssms_ramp_tick.sv */
// per-millisecond step generator: spreads an rpm/sec rate into integer steps
// assumes one clock; tick is a one-cycle enable from the divider
module ssms_ramp_tick
    import ssms_pkg::*;
#(
    parameter int STEP_CYC = 125000
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // rate in rpm per second, and outputs
    input wire logic [15:0] rate,
    output logic tick,
    output logic [15:0] step
);
    logic [$clog2(STEP_CYC)-1:0] div_q;
    logic [25:0] acc_q;
    logic [25:0] acc_sum;
    logic div_end;

    assign div_end = (div_q == ($clog2(STEP_CYC))'(STEP_CYC - 1));
    assign acc_sum = acc_q + {10'h000, rate};

    // divider; the fractional accumulator keeps slow rates exact over a second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
            acc_q <= '0;
            tick <= 1'b0;
            step <= 16'h0000;
        end else begin
            div_q <= div_end ? '0 : div_q + 1'b1;
            tick <= div_end;
            if (div_end) begin
                step <= 16'(acc_sum / 26'd1000);
                acc_q <= acc_sum % 26'd1000;
            end
        end
    end
endmodule

/* File: rtl/ssms_core.sv */
// speed setpoint ramping, frequency arm logic and dual dynamics selection
// assumes all contacts and commands are synchronous and debounced upstream
import ssms_pkg::*;
`include "ssms_defs.svh"

// Notes on behaviour
// - setpoint never above max governor unless overspeed test active
// - after passing min governor, stay above it except idle ramp or stop
// - raise/lower honoured only with speed at or above min governor
// - raise/lower moves setpoint at slow rate
// - after three-second hold, rate becomes three times slow rate
// - entered value ramps toward target at tunable entry rate
// - generator, breaker open, within window of rated: sync window rate
// - tie closed and gen breaker closes: step to minimum load level
// - valve load mode captures valve positions at breaker closure
// - armed: frequency control when tie breaker opens
// - disarmed: stay in unit load when tie breaker opens
// - arm contact closed arms, open disarms; interface may also arm
// - arm selection only with feature, no loadshare, discrete source
// - arming any time; frequency control only gen closed, tie open
// - feature off means permanently armed
// - generator: online dynamics with both breakers closed, else offline
// - non-generator: offline below min governor, online above
// - dynamics contact overrides: open offline, closed online
// - relay output shows selected dynamics
// - setpoint from interface, contacts, serial, analog or cascade
// - entering frequency control steps to speed then ramps to rated
// - generator modes: speed, frequency, unit load by breakers
module ssms_core
    import ssms_pkg::*;
#(
    parameter int FAST_DELAY_MS = `SSMS_FAST_DELAY_MS,
    parameter int STEP_CYC = `SSMS_STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire ssms_cfg_s cfg,
    input wire logic [15:0] min_gov,
    input wire logic [15:0] max_gov,
    input wire logic [15:0] rated,
    input wire logic [15:0] idle_spd,
    // tunable rates and window
    input wire logic [15:0] slow_rate,
    input wire logic [15:0] entry_rate,
    input wire logic [15:0] sync_rate,
    input wire logic [15:0] sync_win,
    input wire logic [15:0] freq_rate,
    input wire logic [7:0] fast_mult,
    input wire logic [7:0] min_load_pct,
    // field contacts and speed
    input wire ssms_contacts_s contacts,
    input wire logic [15:0] speed,
    input wire logic [15:0] valve_hp,
    input wire logic [15:0] valve_lp,
    // operator commands
    input wire logic raise_cmd,
    input wire logic lower_cmd,
    input wire logic entry_valid,
    input wire logic [15:0] entry_value,
    input wire logic direct_valid,
    input wire logic [15:0] direct_value,
    input wire logic arm_cmd,
    input wire logic disarm_cmd,
    input wire logic ovs_test,
    input wire logic idle_cmd,
    input wire logic stop_cmd,
    // status outputs
    output logic [15:0] setpoint,
    output ssms_mode_e mode,
    output logic online_dyn,
    output logic dyn_relay,
    output logic armed,
    output logic arm_avail,
    output logic [15:0] zero_hp,
    output logic [15:0] zero_lp
);
    // ************************************************************
    // rate tick and hold timer
    // ************************************************************
    logic [15:0] rate_sel;
    logic tick;
    logic [15:0] step;
    logic [15:0] sp_q, sp_d;
    logic [15:0] tgt_q;
    logic ramp_q;
    logic above_min_q;
    logic [$clog2(FAST_DELAY_MS+1)-1:0] hold_q;
    logic fast;

    ssms_ramp_tick #(.STEP_CYC(STEP_CYC)) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .rate(rate_sel),
        .tick(tick),
        .step(step)
    );

    // ************************************************************
    // decode of conditions
    // ************************************************************
    wire rl_ok = (speed >= min_gov);
    wire rl_act = rl_ok && (raise_cmd ^ lower_cmd);
    wire [16:0] dist_rated = (sp_q > rated) ? {1'b0, sp_q - rated} : {1'b0, rated - sp_q};
    wire in_win = cfg.gen_app && !contacts.gen_brk && (dist_rated <= {1'b0, sync_win});
    wire [23:0] fast_rate = slow_rate * fast_mult;
    assign fast = (hold_q == ($bits(hold_q))'(FAST_DELAY_MS));
    wire [23:0] min_load_inc = rated * min_load_pct / 8'd100;
    wire [15:0] min_load_sp = 16'(rated + min_load_inc[15:0]);
    wire lim_free = idle_cmd || stop_cmd;
    wire [15:0] hi_lim = ovs_test ? 16'hFFFF : max_gov;
    wire [15:0] lo_lim = (above_min_q && !lim_free) ? min_gov : 16'h0000;
    logic gen_q, tie_q;
    wire gen_close = contacts.gen_brk && !gen_q;
    wire tie_open = !contacts.tie_brk && tie_q;

    logic entry_q;
    // rate priority: sync window, then fast/slow hold, then entry or freq ramp
    assign rate_sel = in_win ? sync_rate :
                      rl_act ? (fast ? 16'(fast_rate) : slow_rate) :
                      (mode == SSMS_FREQ && !entry_q) ? freq_rate : entry_rate;

    // ************************************************************
    // frequency arm and control mode
    // ************************************************************
    assign arm_avail = cfg.arm_feature && !cfg.loadshare_cfg && cfg.discrete_cfg;
    logic arm_q;
    logic arm_ct_q;
    wire arm_eff = arm_avail ? arm_q : 1'b1;
    assign armed = arm_eff;
    wire fc_cond = cfg.gen_app && contacts.gen_brk && !contacts.tie_brk;
    ssms_mode_e mode_d;

    always_comb begin
        mode_d = mode;
        if (!cfg.gen_app || !contacts.gen_brk)
            mode_d = SSMS_SPEED;
        else if (contacts.tie_brk)
            mode_d = SSMS_UNIT_LOAD;
        else if (fc_cond && arm_eff)
            mode_d = SSMS_FREQ;
        else if (mode != SSMS_FREQ)
            mode_d = SSMS_UNIT_LOAD;
    end
    wire enter_fc = (mode_d == SSMS_FREQ) && (mode != SSMS_FREQ);

    // arm latch: contact edges and interface commands, last one wins; in one cycle a contact edge beats a command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arm_q <= 1'b0;
            arm_ct_q <= 1'b0;
            mode <= SSMS_SPEED;
            gen_q <= 1'b0;
            tie_q <= 1'b0;
        end else begin
            arm_ct_q <= contacts.arm_contact;
            if (cfg.arm_contact_cfg && contacts.arm_contact != arm_ct_q)
                arm_q <= contacts.arm_contact;
            else if (arm_cmd)
                arm_q <= 1'b1;
            else if (disarm_cmd)
                arm_q <= 1'b0;
            mode <= mode_d;
            gen_q <= contacts.gen_brk;
            tie_q <= contacts.tie_brk;
        end
    end

    // ************************************************************
    // setpoint ramp
    // ************************************************************
    wire [16:0] up = {1'b0, sp_q} + {1'b0, step};
    wire [15:0] dn = (sp_q > step) ? sp_q - step : 16'h0000;
    logic [15:0] raw;

    always_comb begin
        raw = sp_q;
        if (enter_fc)
            raw = speed;
        else if (cfg.gen_app && cfg.min_load_en && gen_close && contacts.tie_brk)
            raw = min_load_sp;
        else if (direct_valid)
            raw = direct_value;
        else if (tick && rl_act && raise_cmd)
            raw = up[16] ? 16'hFFFF : up[15:0];
        else if (tick && rl_act && lower_cmd)
            raw = dn;
        else if (tick && ramp_q)
            // stop exactly at the target, no overshoot
            raw = (tgt_q > sp_q) ? ((up[15:0] > tgt_q || up[16]) ? tgt_q : up[15:0])
                                 : ((dn < tgt_q) ? tgt_q : dn);
        sp_d = raw;
        if (sp_d > hi_lim)
            sp_d = hi_lim;
        if (sp_d < lo_lim)
            sp_d = lo_lim;
    end

    // idle or stop walks the setpoint down to idle speed
    wire [15:0] tgt_new = lim_free ? idle_spd : enter_fc ? rated : entry_value;
    wire tgt_load = lim_free || enter_fc || entry_valid;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_q <= 16'h0000;
            tgt_q <= 16'h0000;
            ramp_q <= 1'b0;
            entry_q <= 1'b0;
            above_min_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            if (tgt_load) begin
                tgt_q <= tgt_new;
                ramp_q <= 1'b1;
                entry_q <= entry_valid && !enter_fc && !lim_free;
            end else if (rl_act || direct_valid || sp_q == tgt_q) begin
                ramp_q <= 1'b0;
            end
            if (lim_free)
                above_min_q <= 1'b0;
            else if (sp_q > min_gov)
                above_min_q <= 1'b1;
        end
    end
    assign setpoint = sp_q;

    // hold timer counts milliseconds of a continuous raise or lower;
    // a direction change restarts it, so a fresh lower never starts fast
    logic dir_q;
    wire dir_flip = (raise_cmd != dir_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= '0;
            dir_q <= 1'b0;
        end else begin
            dir_q <= raise_cmd;
            if (!rl_act || dir_flip)
                hold_q <= '0;
            else if (tick && !fast)
                hold_q <= hold_q + 1'b1;
        end
    end

    // ************************************************************
    // zero-load valve capture and dynamics select
    // ************************************************************
    logic online_q;
    wire dyn_hold = (speed == min_gov);
    wire dyn_d = cfg.dyn_contact_cfg ? contacts.dyn_contact :
                 cfg.gen_app ? (contacts.gen_brk && contacts.tie_brk) :
                 dyn_hold ? online_q : (speed > min_gov);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_hp <= 16'h0000;
            zero_lp <= 16'h0000;
            online_q <= 1'b0;
        end else begin
            if (cfg.valve_load && gen_close) begin
                zero_hp <= valve_hp;
                zero_lp <= valve_lp;
            end
            online_q <= dyn_d;
        end
    end
    assign online_dyn = online_q;
    assign dyn_relay = online_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_max_clamp;
        @(posedge clk) disable iff (sys_rst) !$past(ovs_test) |-> setpoint <= $past(max_gov);
    endproperty
    a_max_clamp: assert property (p_max_clamp) else $error("setpoint above max governor");

    property p_min_hold;
        @(posedge clk) disable iff (sys_rst) ($past(above_min_q) && !$past(lim_free))
            |-> setpoint >= $past(min_gov);
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("setpoint fell below min governor");

    property p_no_raise_low;
        @(posedge clk) disable iff (sys_rst) (!rl_ok && !tgt_load && !ramp_q && !direct_valid && !gen_close)
            |=> sp_q == $past(sp_q) || sp_q == max_gov || sp_q == min_gov;
    endproperty
    a_no_raise_low: assert property (p_no_raise_low) else $error("raise honoured below min governor");

    property p_arm_avail;
        @(posedge clk) disable iff (sys_rst) arm_avail == (cfg.arm_feature && !cfg.loadshare_cfg && cfg.discrete_cfg);
    endproperty
    a_arm_avail: assert property (p_arm_avail) else $error("arm selection availability wrong");

    property p_fc_only;
        @(posedge clk) disable iff (sys_rst) mode == SSMS_FREQ |-> $past(fc_cond);
    endproperty
    a_fc_only: assert property (p_fc_only) else $error("frequency control without breaker state");

    property p_fc_step;
        @(posedge clk) disable iff (sys_rst) enter_fc && speed <= hi_lim && speed >= lo_lim |=> sp_q == $past(speed);
    endproperty
    a_fc_step: assert property (p_fc_step) else $error("no step to sensed speed");

    property p_gen_dyn;
        @(posedge clk) disable iff (sys_rst) (cfg.gen_app && !cfg.dyn_contact_cfg) [*2]
            |-> online_dyn == $past(contacts.gen_brk && contacts.tie_brk);
    endproperty
    a_gen_dyn: assert property (p_gen_dyn) else $error("generator dynamics wrong");

    property p_dyn_contact;
        @(posedge clk) disable iff (sys_rst) cfg.dyn_contact_cfg |=> online_dyn == $past(contacts.dyn_contact);
    endproperty
    a_dyn_contact: assert property (p_dyn_contact) else $error("dynamics contact ignored");

    property p_equal_hold;
        @(posedge clk) disable iff (sys_rst) (!cfg.gen_app && !cfg.dyn_contact_cfg && dyn_hold) |=> $stable(online_dyn);
    endproperty
    a_equal_hold: assert property (p_equal_hold) else $error("dynamics changed at min governor");

    property p_zero_capture;
        @(posedge clk) disable iff (sys_rst) cfg.valve_load && gen_close
            |=> zero_hp == $past(valve_hp) && zero_lp == $past(valve_lp);
    endproperty
    a_zero_capture: assert property (p_zero_capture) else $error("valve zero not captured");

    property p_min_load;
        @(posedge clk) disable iff (sys_rst) cfg.gen_app && cfg.min_load_en && gen_close && contacts.tie_brk
            && min_load_sp <= hi_lim && min_load_sp >= lo_lim |=> setpoint == $past(min_load_sp);
    endproperty
    a_min_load: assert property (p_min_load) else $error("no step to minimum load");

    property p_disarmed_stay;
        @(posedge clk) disable iff (sys_rst) mode == SSMS_UNIT_LOAD && !armed |=> mode != SSMS_FREQ;
    endproperty
    a_disarmed_stay: assert property (p_disarmed_stay) else $error("disarmed unit left unit load");

    // coverage of the main scenarios
    c_fc: cover property (@(posedge clk) disable iff (sys_rst) enter_fc);
    c_fast: cover property (@(posedge clk) disable iff (sys_rst) fast && rl_act);
    c_minload: cover property (@(posedge clk) disable iff (sys_rst) gen_close && contacts.tie_brk);
    c_ovs: cover property (@(posedge clk) disable iff (sys_rst) ovs_test && setpoint > max_gov);
    c_tie_disarmed: cover property (@(posedge clk) disable iff (sys_rst) tie_open && !arm_eff);
endmodule

/* File: test/ssms_field_model.sv */
// field side model: breakers, arm and dynamics contacts, sensed turbine speed
// assumes the bench requests contact states and a speed target off the clock edge
module ssms_field_model
    import ssms_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requested field state
    input wire ssms_contacts_s req,
    input wire logic [15:0] spd_tgt,
    // field signals seen by the block
    output ssms_contacts_s contacts,
    output logic [15:0] speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // contacts and rotor
    // ************************************************************
    // speed slews a few rpm per cycle: a rotor cannot jump to its target
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            contacts <= '0;
            speed <= 16'h0000;
        end else begin
            contacts <= req;
            if (speed + 16'h0008 <= spd_tgt) begin
                speed <= speed + 16'h0008;
            end else if (speed >= spd_tgt + 16'h0008) begin
                speed <= speed - 16'h0008;
            end else begin
                speed <= spd_tgt;
            end
        end
    end
endmodule

/* File: test/speed_setpoint_mode_select_tb_top.sv */
// self-checking bench for the setpoint ramp, arm logic and dynamics selection
// assumes ssms_core with shortened tick and hold counts, field model on the far side
module speed_setpoint_mode_select_tb_top
    import ssms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, raise_cmd, lower_cmd, entry_valid, direct_valid, arm_cmd, disarm_cmd;
    logic ovs_test, idle_cmd, stop_cmd, online_dyn, dyn_relay, armed, arm_avail;
    logic [15:0] min_gov, max_gov, rated, idle_spd, slow_rate, entry_rate, sync_rate, sync_win, freq_rate;
    logic [15:0] speed, spd_tgt, valve_hp, valve_lp, entry_value, direct_value, setpoint, zero_hp, zero_lp, s0;
    logic [7:0] fast_mult, min_load_pct;
    ssms_cfg_s cfg;
    ssms_contacts_s contacts, req;
    ssms_mode_e mode;
    int fail_count, n_checks, cycles;
    // ************************************************************
    // design and field model
    // ************************************************************
    ssms_core #(.FAST_DELAY_MS(5), .STEP_CYC(10)) dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
        .min_gov(min_gov), .max_gov(max_gov), .rated(rated), .idle_spd(idle_spd), .slow_rate(slow_rate),
        .entry_rate(entry_rate), .sync_rate(sync_rate), .sync_win(sync_win), .freq_rate(freq_rate),
        .fast_mult(fast_mult), .min_load_pct(min_load_pct), .contacts(contacts), .speed(speed),
        .valve_hp(valve_hp), .valve_lp(valve_lp), .raise_cmd(raise_cmd), .lower_cmd(lower_cmd),
        .entry_valid(entry_valid), .entry_value(entry_value), .direct_valid(direct_valid),
        .direct_value(direct_value), .arm_cmd(arm_cmd), .disarm_cmd(disarm_cmd), .ovs_test(ovs_test),
        .idle_cmd(idle_cmd), .stop_cmd(stop_cmd), .setpoint(setpoint), .mode(mode), .online_dyn(online_dyn),
        .dyn_relay(dyn_relay), .armed(armed), .arm_avail(arm_avail), .zero_hp(zero_hp), .zero_lp(zero_lp));
    ssms_field_model field (.clk(clk), .sys_rst(sys_rst), .req(req), .spd_tgt(spd_tgt),
        .contacts(contacts), .speed(speed));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp, input string m);
        chk_v({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    task automatic chk_m(input ssms_mode_e exp, input string m);
        chk_v({14'h0000, mode}, {14'h0000, exp}, m);
    endtask
    // one-cycle pulse of an entered or direct value
    task automatic send(input logic direct, input logic [15:0] v);
        @(negedge clk);
        entry_value = v;
        direct_value = v;
        entry_valid = !direct;
        direct_valid = direct;
        @(negedge clk);
        entry_valid = 1'b0;
        direct_valid = 1'b0;
    endtask
    task automatic arm_pulse(input logic a);
        @(negedge clk);
        arm_cmd = a;
        disarm_cmd = !a;
        @(negedge clk);
        arm_cmd = 1'b0;
        disarm_cmd = 1'b0;
    endtask
    // bounded waits, so a stuck ramp or mode cannot hang the run
    task automatic wait_sp(input logic [15:0] exp, input int lim);
        for (int i = 0; i < lim && setpoint !== exp; i++) @(negedge clk);
    endtask
    task automatic wait_md(input ssms_mode_e exp, input int lim);
        for (int i = 0; i < lim && mode !== exp; i++) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ************************************************************
    // clock, reset and timeout
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // the whole sequence needs under 15000 cycles; double that is a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            print_verdict();
        end
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        cfg = '0; // no power feedback droop nor decoupled ratio mode is modelled
        req = '0;
        {min_gov, max_gov, rated, idle_spd} = {16'h0BB8, 16'h0C80, 16'h0C1C, 16'h03E8};
        {slow_rate, entry_rate, sync_rate, freq_rate} = {16'h03E8, 16'h07D0, 16'h01F4, 16'h03E8};
        {sync_win, fast_mult, min_load_pct} = {16'h000A, 8'h03, 8'h03};
        {spd_tgt, valve_hp, valve_lp, entry_value, direct_value} = '0;
        {raise_cmd, lower_cmd, entry_valid, direct_valid, arm_cmd, disarm_cmd} = '0;
        {ovs_test, idle_cmd, stop_cmd} = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk_v(setpoint, 16'h0000, "reset setpoint");
        chk_m(SSMS_SPEED, "reset mode");
        // raise refused while the turbine is still below minimum governor
        raise_cmd = 1'b1;
        cyc(50);
        chk_v(setpoint, 16'h0000, "raise below min governor");
        chk_b(online_dyn, 1'b0, "offline below min governor");
        raise_cmd = 1'b0;
        $display("test refusal done");
        // non-generator dynamics: speed criteria, equal speed keeps, contact overrides
        spd_tgt = 16'h0C1C;
        cyc(450);
        chk_b(online_dyn, 1'b1, "online above min governor");
        chk_b(dyn_relay, 1'b1, "relay follows dynamics");
        spd_tgt = 16'h0BB8;
        cyc(30);
        chk_b(online_dyn, 1'b1, "equal speed keeps online");
        spd_tgt = 16'h0B54;
        cyc(30);
        chk_b(online_dyn, 1'b0, "offline below again");
        chk_b(dyn_relay, 1'b0, "relay shows offline");
        cfg.dyn_contact_cfg = 1'b1;
        req.dyn_contact = 1'b1;
        cyc(5);
        chk_b(online_dyn, 1'b1, "contact closed online");
        spd_tgt = 16'h0C1C;
        req.dyn_contact = 1'b0;
        cyc(30);
        chk_b(online_dyn, 1'b0, "contact open offline");
        cfg.dyn_contact_cfg = 1'b0;
        $display("test dynamics done");
        // direct and entered values, exact landing and hold
        send(1'b1, 16'h0BEA);
        chk_v(setpoint, 16'h0BEA, "direct value");
        send(1'b0, 16'h0BFE);
        wait_sp(16'h0BFE, 200);
        cyc(50);
        chk_v(setpoint, 16'h0BFE, "entry landed and held");
        // raise: slow first, fast after the hold delay, clamp at maximum
        s0 = setpoint;
        raise_cmd = 1'b1;
        cyc(30);
        chk_v(setpoint - s0, 16'h0003, "slow raise rate");
        cyc(60);
        s0 = setpoint;
        cyc(100);
        chk_v(setpoint - s0, 16'h001E, "fast raise rate");
        cyc(400);
        chk_v(setpoint, 16'h0C80, "clamp at max governor");
        ovs_test = 1'b1;
        cyc(100);
        chk_b(setpoint > 16'h0C80, 1'b1, "overspeed test passes max");
        raise_cmd = 1'b0;
        ovs_test = 1'b0;
        lower_cmd = 1'b1;
        cyc(2000);
        chk_v(setpoint, 16'h0BB8, "clamp at min governor");
        lower_cmd = 1'b0;
        idle_cmd = 1'b1;
        cyc(300);
        chk_b(setpoint < 16'h0BB8, 1'b1, "idle ramp goes below min");
        idle_cmd = 1'b0;
        $display("test raise_lower done");
        // generator: sync window rate, minimum load step, valve zero capture
        cfg.gen_app = 1'b1;
        cfg.min_load_en = 1'b1;
        cfg.valve_load = 1'b1;
        send(1'b1, 16'h0C17);
        chk_m(SSMS_SPEED, "gen open speed control");
        chk_b(online_dyn, 1'b0, "gen open offline");
        send(1'b0, 16'h0C21);
        s0 = setpoint;
        cyc(100);
        chk_b((setpoint - s0) >= 16'h0004 && (setpoint - s0) <= 16'h0006, 1'b1, "sync window rate");
        wait_sp(16'h0C21, 1000);
        {valve_hp, valve_lp} = {16'h0123, 16'h0456};
        req.tie_brk = 1'b1;
        cyc(2);
        req.gen_brk = 1'b1;
        cyc(4);
        chk_m(SSMS_UNIT_LOAD, "both closed unit load");
        chk_b(online_dyn, 1'b1, "both closed online");
        chk_v(setpoint, 16'h0C79, "minimum load step");
        {valve_hp, valve_lp} = {16'h0789, 16'h0ABC};
        cyc(2);
        chk_v(zero_hp, 16'h0123, "hp zero load captured");
        chk_v(zero_lp, 16'h0456, "lp zero load captured");
        // feature off: always armed, tie opening enters frequency control
        freq_rate = 16'h0000;
        spd_tgt = 16'h0C4E;
        cyc(20);
        req.tie_brk = 1'b0;
        wait_md(SSMS_FREQ, 10);
        chk_m(SSMS_FREQ, "tie open frequency control");
        chk_v(setpoint, 16'h0C4E, "step to sensed speed");
        cyc(2);
        chk_b(online_dyn, 1'b0, "tie open offline");
        freq_rate = 16'h03E8;
        wait_sp(16'h0C1C, 1000);
        cyc(30);
        chk_v(setpoint, 16'h0C1C, "ramp to rated and hold");
        $display("test generator done");
        // arm and disarm selection
        req.tie_brk = 1'b1;
        {cfg.arm_feature, cfg.discrete_cfg, cfg.loadshare_cfg} = 3'b111;
        cyc(3);
        chk_b(arm_avail, 1'b0, "no arm with loadshare");
        cfg.loadshare_cfg = 1'b0;
        arm_pulse(1'b0);
        cyc(2);
        chk_b(arm_avail, 1'b1, "arm selection offered");
        chk_b(armed, 1'b0, "disarmed");
        req.tie_brk = 1'b0;
        cyc(5);
        chk_m(SSMS_UNIT_LOAD, "disarmed stays unit load");
        arm_pulse(1'b1);
        wait_md(SSMS_FREQ, 10);
        chk_m(SSMS_FREQ, "late arm engages");
        arm_pulse(1'b0);
        cfg.arm_contact_cfg = 1'b1;
        req.arm_contact = 1'b1;
        cyc(4);
        chk_b(armed, 1'b1, "contact closed arms");
        req.arm_contact = 1'b0;
        cyc(4);
        chk_b(armed, 1'b0, "contact open disarms");
        $display("test arming done");
        print_verdict();
    end
endmodule
